// ===== rtl/sic_ctrl_status.sv
// system integrity control/status register with apb slave
// assumes monitor inputs synchronous to core_clk; porRst pulses once at power-up
`timescale 1ns/100ps
module sic_ctrl_status
   import sic_pkg::*;
#(
   parameter int ADDR_W = 12
) (
   input wire logic core_clk,
   input wire logic rst,
   input wire logic ce,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [ADDR_W-1:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0] pstrb,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire sic_mon_t mon,
   output sic_clk_t clkCtl,
   output logic supplyIrq,
   output logic clkGuardIrq
);
   logic preadyR;
   logic [31:0] prdataR;
   logic pslverrR;
   logic pageSel_r;
   logic supIe_r;
   logic supFlag_r;
   logic supPend_r;
   logic uvFlag_r;
   logic wdFlag_r;
   logic cgIe_r;
   logic cgFlag_r;
   logic oscMode_r;
   logic pll_enable_bit_r;
   logic clkSel_r;
   logic supIrq_r;
   logic cgIrq_r;
   sic_clk_t clk_r;
   logic hit;
   logic access;
   logic wrEn;
   logic rdEn;
   logic wr0;
   logic wr1;
   logic rd0;
   logic supFlag_nxt;
   logic [7:0] wb;
   logic [7:0] page0;
   logic [7:0] page1;

   function automatic logic [31:0] widen(input logic [7:0] v);
      return {24'h00_0000, v};
   endfunction

   assign hit = (paddr == SIC_REG_ADDR[ADDR_W-1:0]);
   assign access = ce && psel && penable && preadyR;
   assign wrEn = access && pwrite && hit && pstrb[0];
   assign rdEn = access && !pwrite && hit;
   assign wb = pwdata[7:0];
   assign wr0 = wrEn && !pageSel_r;
   assign wr1 = wrEn && pageSel_r;
   assign rd0 = rdEn && !pageSel_r;
   assign supFlag_nxt = mon.uvOptEn && mon.supplyBelow;

   assign page0 = {pageSel_r, supIe_r, supFlag_r, uvFlag_r, 1'b0, cgIe_r,
                   cgFlag_r && pll_enable_bit_r, wdFlag_r};
   assign page1 = {pageSel_r, 1'b0, oscMode_r, mon.pllLocked && pll_enable_bit_r,
                   pll_enable_bit_r, 1'b0, clkSel_r, 1'b0};

   // zero-wait slave: ready rises in the access phase of every transfer
   always_ff @(posedge core_clk) begin
      if (rst) begin
         preadyR <= 1'b0;
         prdataR <= SIC_RDATA_RST;
         pslverrR <= 1'b0;
      end else if (ce) begin
         preadyR <= psel && !penable && !preadyR;
         pslverrR <= psel && !penable && !hit;
         if (psel && !penable && hit && !pwrite) begin
            prdataR <= widen(pageSel_r ? page1 : page0);
         end else begin
            prdataR <= SIC_RDATA_RST;
         end
      end
   end

   // one page bit shared by both views
   always_ff @(posedge core_clk) begin
      if (rst) begin
         pageSel_r <= SIC_CTRL_RST;
      end else if (ce && wrEn) begin
         pageSel_r <= wb[SIC_PAGE_BIT];
      end
   end

   // page zero enables
   always_ff @(posedge core_clk) begin
      if (rst) begin
         supIe_r <= SIC_CTRL_RST;
         cgIe_r <= SIC_CTRL_RST;
      end else if (ce && wr0) begin
         supIe_r <= wb[SIC_SUP_IE_BIT];
         cgIe_r <= wb[SIC_CG_IE_BIT];
      end
   end

   // supply monitor: a toggle of the flag is an event only while supIe_r and mon.uvOptEn are set; set wins over isr clear
   always_ff @(posedge core_clk) begin
      if (rst) begin
         supFlag_r <= SIC_CTRL_RST;
         supPend_r <= SIC_CTRL_RST;
      end else if (ce) begin
         supFlag_r <= supFlag_nxt;
         if (supIe_r && mon.uvOptEn && (supFlag_nxt != supFlag_r)) begin
            supPend_r <= 1'b1;
         end else if (mon.supIsrEnter || !supIe_r) begin
            supPend_r <= 1'b0;
         end
      end
   end

   // reset-cause flags are deliberately outside rst so the cause outlives it
   always_ff @(posedge core_clk) begin
      if (ce) begin
         if (mon.porRst) begin
            uvFlag_r <= 1'b0;
            wdFlag_r <= 1'b0;
         end else if (mon.uvRst) begin
            uvFlag_r <= 1'b1;
            wdFlag_r <= 1'b0;
         end else if (mon.wdRst) begin
            wdFlag_r <= 1'b1;
         end else if (wr0) begin
            if (!wb[SIC_UV_RST_BIT]) begin
               uvFlag_r <= 1'b0;
            end
            if (!wb[SIC_WD_RST_BIT]) begin
               wdFlag_r <= 1'b0;
            end
         end
      end
   end

   // clock guard flag: stopped oscillator sets, read clears only after recovery
   always_ff @(posedge core_clk) begin
      if (rst) begin
         cgFlag_r <= SIC_CTRL_RST;
      end else if (ce) begin
         if (!pll_enable_bit_r) begin
            cgFlag_r <= 1'b0;
         end else if (mon.oscStopped) begin
            cgFlag_r <= 1'b1;
         end else if (rd0) begin
            cgFlag_r <= 1'b0;
         end
      end
   end

   // page one controls; the session override beats any software write
   always_ff @(posedge core_clk) begin
      if (rst) begin
         oscMode_r <= SIC_CTRL_RST;
         pll_enable_bit_r <= SIC_CTRL_RST;
         clkSel_r <= SIC_CTRL_RST;
      end else if (ce) begin
         if (mon.progSession) begin
            oscMode_r <= 1'b1;
            pll_enable_bit_r <= 1'b1;
            clkSel_r <= 1'b1;
         end else if (wr1) begin
            oscMode_r <= wb[SIC_OSC_MODE_BIT];
            if (!clkSel_r || wb[SIC_PLL_EN_BIT]) begin
               pll_enable_bit_r <= wb[SIC_PLL_EN_BIT];
            end
            // the pll must stay on through the write that selects it
            if (!mon.pllClkOpt && ((pll_enable_bit_r && wb[SIC_PLL_EN_BIT]) || !wb[SIC_CLK_SEL_BIT])) begin
               clkSel_r <= wb[SIC_CLK_SEL_BIT];
            end
         end
      end
   end

   // outputs registered; the option strap selects the pll on its own
   always_ff @(posedge core_clk) begin
      if (rst) begin
         clk_r <= '0;
         supIrq_r <= 1'b0;
         cgIrq_r <= 1'b0;
      end else if (ce) begin
         clk_r.oscGrounded <= oscMode_r;
         clk_r.pllOn <= pll_enable_bit_r;
         clk_r.detectorOn <= pll_enable_bit_r;
         clk_r.selPll <= (clkSel_r && pll_enable_bit_r) || mon.pllClkOpt;
         supIrq_r <= supPend_r && supIe_r && !mon.globalMask;
         cgIrq_r <= cgFlag_r && cgIe_r && pll_enable_bit_r && !mon.globalMask;
      end
   end

   assign prdata = prdataR;
   assign pready = preadyR;
   assign pslverr = pslverrR;
   assign clkCtl = clk_r;
   assign supplyIrq = supIrq_r;
   assign clkGuardIrq = cgIrq_r;

   default clocking cb @(posedge core_clk);
   endclocking
   default disable iff (rst);

   sequence s_pageWrite;
      wrEn ##1 ce;
   endsequence

   sequence s_readSetup;
      ce && psel && !penable && hit && !pwrite;
   endsequence

   property p_pageSel;
      s_pageWrite |-> pageSel_r == $past(wb[SIC_PAGE_BIT]);
   endproperty
   a_pageSel: assert property (p_pageSel) else $error("page bit not stored");

   property p_pageShared;
      s_readSetup |=> prdataR[SIC_PAGE_BIT] == $past(pageSel_r);
   endproperty
   a_pageShared: assert property (p_pageShared) else $error("page bit view differs");

   sequence s_supToggle;
      ce && supIe_r && mon.uvOptEn && (supFlag_nxt != supFlag_r);
   endsequence

   property p_supIrq;
      s_supToggle ##1 (ce && !mon.globalMask && supIe_r) |=> supIrq_r;
   endproperty
   a_supIrq: assert property (p_supIrq) else $error("supply toggle lost");

   property p_isrClear;
      ce && mon.supIsrEnter && (supFlag_nxt == supFlag_r) |=> !supPend_r;
   endproperty
   a_isrClear: assert property (p_isrClear) else $error("pending not cleared on isr");

   property p_supFlag;
      ce |=> supFlag_r == $past(mon.uvOptEn && mon.supplyBelow);
   endproperty
   a_supFlag: assert property (p_supFlag) else $error("supply flag mismatch");

   property p_uvKeep;
      ce && mon.wdRst && !mon.uvRst && !mon.porRst |=> $stable(uvFlag_r) && wdFlag_r;
   endproperty
   a_uvKeep: assert property (p_uvKeep) else $error("undervoltage flag disturbed");

   property p_cgForce;
      ce && !pll_enable_bit_r |=> !cgFlag_r && !prdataR[SIC_CG_FLAG_BIT];
   endproperty
   a_cgForce: assert property (p_cgForce) else $error("guard flag with pll off");

   property p_pllKeep;
      ce && wr1 && clkSel_r && !wb[SIC_PLL_EN_BIT] && !mon.progSession |=> pll_enable_bit_r;
   endproperty
   a_pllKeep: assert property (p_pllKeep) else $error("pll cleared while selected");

   property p_selRefuse;
      ce && wr1 && !pll_enable_bit_r && !clkSel_r && !mon.progSession |=> !clkSel_r;
   endproperty
   a_selRefuse: assert property (p_selRefuse) else $error("pll selected while off");

   property p_optIgnore;
      ce && wr1 && mon.pllClkOpt && !mon.progSession |=> $stable(clkSel_r);
   endproperty
   a_optIgnore: assert property (p_optIgnore) else $error("select written under option");

   property p_session;
      ce && mon.progSession |=> oscMode_r && pll_enable_bit_r && clkSel_r;
   endproperty
   a_session: assert property (p_session) else $error("session override missing");

   property p_cgIrq;
      ce && cgFlag_r && cgIe_r && pll_enable_bit_r && !mon.globalMask |=> cgIrq_r;
   endproperty
   a_cgIrq: assert property (p_cgIrq) else $error("guard interrupt missing");

   property p_page0Reset;
      disable iff (1'b0) rst |=> (page0 & 8'hEE) == 8'h00;
   endproperty
   a_page0Reset: assert property (p_page0Reset) else $error("page zero reset value");

   property p_page1Reset;
      disable iff (1'b0) rst |=> page1 == 8'h00;
   endproperty
   a_page1Reset: assert property (p_page1Reset) else $error("page one reset value");

   property p_cgSet;
      ce && pll_enable_bit_r && mon.oscStopped |=> cgFlag_r;
   endproperty
   a_cgSet: assert property (p_cgSet) else $error("guard flag not set");

   property p_cgHold;
      ce && pll_enable_bit_r && cgFlag_r && !rd0 |=> cgFlag_r;
   endproperty
   a_cgHold: assert property (p_cgHold) else $error("guard flag lost without read");

   property p_cgReadClear;
      rd0 && pll_enable_bit_r && !mon.oscStopped |=> !cgFlag_r;
   endproperty
   a_cgReadClear: assert property (p_cgReadClear) else $error("guard flag not read-cleared");

   property p_uvSet;
      ce && mon.uvRst && !mon.porRst |=> uvFlag_r;
   endproperty
   a_uvSet: assert property (p_uvSet) else $error("undervoltage flag not set");

   property p_uvSticky;
      ce && uvFlag_r && !mon.porRst && !wr0 |=> uvFlag_r;
   endproperty
   a_uvSticky: assert property (p_uvSticky) else $error("undervoltage flag dropped");

   property p_uvClear;
      wr0 && !wb[SIC_UV_RST_BIT] && !mon.porRst && !mon.uvRst && !mon.wdRst |=> !uvFlag_r;
   endproperty
   a_uvClear: assert property (p_uvClear) else $error("undervoltage flag not cleared");

   property p_wdOnUv;
      ce && mon.uvRst && !mon.porRst |=> !wdFlag_r;
   endproperty
   a_wdOnUv: assert property (p_wdOnUv) else $error("watchdog flag kept on undervoltage");

   property p_wdClear;
      wr0 && !wb[SIC_WD_RST_BIT] && !mon.porRst && !mon.uvRst && !mon.wdRst |=> !wdFlag_r;
   endproperty
   a_wdClear: assert property (p_wdClear) else $error("watchdog flag not cleared");

   property p_pairWd;
      ce && mon.wdRst && !mon.uvRst && !mon.porRst && !uvFlag_r |=> !uvFlag_r && wdFlag_r;
   endproperty
   a_pairWd: assert property (p_pairWd) else $error("watchdog cause code wrong");

   property p_pairPor;
      ce && mon.porRst |=> !uvFlag_r && !wdFlag_r;
   endproperty
   a_pairPor: assert property (p_pairPor) else $error("power-up cause code wrong");

   property p_maskOff;
      ce && mon.globalMask |=> !supIrq_r && !cgIrq_r;
   endproperty
   a_maskOff: assert property (p_maskOff) else $error("interrupt through mask");

   property p_cgNoEn;
      ce && !pll_enable_bit_r |=> !cgIrq_r;
   endproperty
   a_cgNoEn: assert property (p_cgNoEn) else $error("guard interrupt with pll off");

   property p_supOptOff;
      ce && !mon.uvOptEn |=> !supFlag_r;
   endproperty
   a_supOptOff: assert property (p_supOptOff) else $error("supply flag without option");

   property p_selNeedsPll;
      clkSel_r |-> pll_enable_bit_r;
   endproperty
   a_selNeedsPll: assert property (p_selNeedsPll) else $error("pll selected but off");

   property p_oscWrite;
      wr1 && !mon.progSession |=> oscMode_r == $past(wb[SIC_OSC_MODE_BIT]);
   endproperty
   a_oscWrite: assert property (p_oscWrite) else $error("oscillator mode not stored");

   property p_optSel;
      ce && mon.pllClkOpt |=> clk_r.selPll;
   endproperty
   a_optSel: assert property (p_optSel) else $error("option did not select pll");

   property p_lockRead;
      s_readSetup ##0 pageSel_r |=> prdataR[SIC_LOCK_BIT] == $past(mon.pllLocked && pll_enable_bit_r);
   endproperty
   a_lockRead: assert property (p_lockRead) else $error("lock bit view wrong");
endmodule

// ===== include/sic_pkg.sv
// constants, field layout and carriers of the system integrity control/status register
// assumes one 8-bit register window at one aligned apb word, two pages
package sic_pkg;
   localparam logic [11:0] SIC_REG_ADDR = 12'h000;
   localparam int SIC_PAGE_BIT = 7;
   localparam int SIC_SUP_IE_BIT = 6;
   localparam int SIC_SUP_FLAG_BIT = 5;
   localparam int SIC_UV_RST_BIT = 4;
   localparam int SIC_CG_IE_BIT = 2;
   localparam int SIC_CG_FLAG_BIT = 1;
   localparam int SIC_WD_RST_BIT = 0;
   localparam int SIC_OSC_MODE_BIT = 5;
   localparam int SIC_LOCK_BIT = 4;
   localparam int SIC_PLL_EN_BIT = 3;
   localparam int SIC_CLK_SEL_BIT = 1;
   localparam logic SIC_CTRL_RST = 1'b0;
   localparam logic [31:0] SIC_RDATA_RST = 32'h0000_0000;

   // monitor, reset-cause and cpu-side inputs
   typedef struct packed {
      logic supplyBelow;
      logic oscStopped;
      logic pllLocked;
      logic porRst;
      logic uvRst;
      logic wdRst;
      logic progSession;
      logic uvOptEn;
      logic pllClkOpt;
      logic supIsrEnter;
      logic globalMask;
   } sic_mon_t;

   // clock tree controls
   typedef struct packed {
      logic oscGrounded;
      logic pllOn;
      logic detectorOn;
      logic selPll;
   } sic_clk_t;
endpackage

// ===== tb/sic_testbench.sv
// self-checking bench for the integrity control/status register
// assumes the apb slave answers with one access cycle; reset-cause flags kept across rst
`timescale 1ns/100ps
`define CHK(nm, ex, got) begin checksDone++; if ((got) !== (ex)) begin badCount++; \
   $display("CHECK FAILED %s exp %h got %h", nm, ex, got); end end
module testbench;
   import sic_pkg::*;
   typedef struct packed {
      logic [7:0] data;
      logic err;
   } sic_exp_t;
   // bit index of each monitor input inside the packed struct
   localparam int BELOW = 10, OSCSTOP = 9, LOCKED = 8, POR = 7, UVR = 6, WDR = 5;
   localparam int PROG = 4, UVOPT = 3, PLLOPT = 2, ISR = 1, GMASK = 0;
   logic core_clk, rst, ce, psel, penable, pwrite, pslverr, pready, supplyIrq, clkGuardIrq;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata;
   logic [3:0] pstrb;
   sic_mon_t mon;
   sic_clk_t clkCtl;
   sic_exp_t expQ[$];
   sic_exp_t ex;
   int badCount = 0, checksDone = 0, n;
   sic_ctrl_status #(.ADDR_W(12)) dut_u (.core_clk(core_clk), .rst(rst), .ce(ce), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
      .prdata(prdata), .pready(pready), .pslverr(pslverr), .mon(mon), .clkCtl(clkCtl),
      .supplyIrq(supplyIrq), .clkGuardIrq(clkGuardIrq));
   initial begin
      core_clk = 1'b0;
      forever #50 core_clk = ~core_clk;
   end
   task conclude;
      if (badCount == 0 && checksDone > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask
   // request held until pready is seen; release only after that edge
   task apb(input logic w, input logic [11:0] a, input logic [7:0] d, input logic [7:0] e);
      expQ.push_back('{e, a != 12'h000});
      @(posedge core_clk);
      psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= {24'h0, d};
      @(posedge core_clk);
      penable <= 1'b1;
      n = 0;
      do begin @(posedge core_clk); n++; end while (pready !== 1'b1 && n < 20);
      if (n >= 20) begin badCount++; conclude(); end
      psel <= 1'b0; penable <= 1'b0;
   endtask
   task wr(input logic [7:0] d); apb(1'b1, 12'h000, d, 8'h00); endtask
   task rd(input logic [7:0] e); apb(1'b0, 12'h000, 8'h00, e); endtask
   task sm(input int b, input logic v); @(posedge core_clk); mon[b] <= v; endtask
   task pulse(input int b); sm(b, 1'b1); sm(b, 1'b0); endtask
   task settle(input int k); repeat (k) @(posedge core_clk); #1; endtask
   // response watcher: oldest note against each completed transfer
   always @(posedge core_clk) begin
      if (psel && penable && pready === 1'b1) begin
         ex = expQ.pop_front();
         `CHK("pslverr", ex.err, pslverr)
         if (!pwrite && !ex.err) `CHK("prdata", ex.data, prdata[7:0])
      end
   end
   initial begin
      repeat (5000) @(posedge core_clk);
      badCount++;
      conclude();
   end
   initial begin
      n = $urandom(32'h2E8EE487);
      rst = 1'b1; ce = 1'b1; psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
      paddr = 12'h000; pwdata = 32'h0; pstrb = 4'hF; mon = '0; mon.uvOptEn = 1'b1;
      repeat (10) @(posedge core_clk);
      rst <= 1'b0;
      pulse(POR);
      rd(8'h00);
      apb(1'b1, 12'h004 + 12'($urandom % 1000) * 12'h004, 8'($urandom), 8'h00);
      rd(8'h00);
      wr(8'h80);
      rd(8'h80);
      rd(8'h80);
      wr(8'h82);
      rd(8'h80);
      wr(8'h88);
      rd(8'h88);
      `CHK("clkCtl", 4'b0110, clkCtl)
      wr(8'h8A);
      settle(2);
      `CHK("clkCtl", 4'b0111, clkCtl)
      wr(8'h80);
      rd(8'h88);
      sm(LOCKED, 1'b1);
      rd(8'h98);
      wr(8'hA8);
      rd(8'hB8);
      `CHK("clkCtl", 4'b1110, clkCtl)
      wr(8'h88);
      sm(PLLOPT, 1'b1);
      wr(8'h8A);
      settle(2);
      `CHK("clkCtl", 4'b0111, clkCtl)
      sm(PLLOPT, 1'b0);
      rd(8'h98);
      sm(PROG, 1'b1);
      settle(2);
      rd(8'hBA);
      sm(PROG, 1'b0);
      wr(8'h88);
      wr(8'h08);
      wr(8'h04);
      sm(OSCSTOP, 1'b1);
      settle(3);
      `CHK("clkGuardIrq", 1'b1, clkGuardIrq)
      rd(8'h06);
      sm(GMASK, 1'b1);
      settle(3);
      `CHK("clkGuardIrq", 1'b0, clkGuardIrq)
      sm(GMASK, 1'b0);
      sm(OSCSTOP, 1'b0);
      rd(8'h06);
      rd(8'h04);
      sm(OSCSTOP, 1'b1);
      wr(8'h84);
      wr(8'h80);
      wr(8'h00);
      rd(8'h04);
      settle(3);
      `CHK("clkGuardIrq", 1'b0, clkGuardIrq)
      sm(OSCSTOP, 1'b0);
      wr(8'h44);
      sm(BELOW, 1'b1);
      settle(3);
      `CHK("supplyIrq", 1'b1, supplyIrq)
      rd(8'h64);
      pulse(ISR);
      settle(3);
      `CHK("supplyIrq", 1'b0, supplyIrq)
      sm(BELOW, 1'b0);
      settle(3);
      `CHK("supplyIrq", 1'b1, supplyIrq)
      pulse(ISR);
      sm(UVOPT, 1'b0);
      sm(BELOW, 1'b1);
      settle(3);
      rd(8'h44);
      `CHK("supplyIrq", 1'b0, supplyIrq)
      @(posedge core_clk);
      ce <= 1'b0;
      sm(UVOPT, 1'b1);
      settle(3);
      `CHK("supplyIrq", 1'b0, supplyIrq)
      ce <= 1'b1;
      settle(3);
      `CHK("supplyIrq", 1'b1, supplyIrq)
      pulse(WDR);
      rd(8'h65);
      pulse(UVR);
      rd(8'h74);
      pulse(WDR);
      rd(8'h75);
      sm(BELOW, 1'b0);
      @(posedge core_clk);
      rst <= 1'b1;
      repeat (2) @(posedge core_clk);
      rst <= 1'b0;
      rd(8'h11);
      pstrb <= 4'h0;
      apb(1'b1, 12'h000, 8'($urandom) & 8'hF7, 8'h00);
      pstrb <= 4'hF;
      rd(8'h11);
      wr(8'h00);
      rd(8'h00);
      conclude();
   end
endmodule
